// ==== hw/tasf_forward.sv ====
`timescale 1ns/1ps
// Behaviour
// - trunks hold exactly two, four or eight ports; bandwidth is members summed.
// - pairs join port n with n+12 only; ports 1..24 alone may trunk.
// - four-port trunks join two adjacent allowed pairs only.
// - eight-port trunks join four consecutive pairs: 1-4/13-16, 5-8/17-20, 9-12/21-24.
// - a port sits in at most one trunk; overlapping adds are rejected.
// - trunk traffic spreads over active members; failed member's load moves to others.
// - a disconnected, disabled member's traffic moves to the remaining members.
// - all trunk members share one spanning-tree forwarding state.
// - static unicast entries never age and learning never rebinds them.
// - frames whose source matches a static entry on a wrong port are dropped.
// - each static unicast entry binds one MAC address to one port.
// - static multicast entry holds MAC, VLAN and 26-port member set; never ages.
// - static multicast matches forward to the entry's ports instead of the request's; an active trunk there sends to one up member by hash.
module tasf_forward
  import tasf_pkg::*;
(
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  // port status
  input  wire logic [tasf_pkg::NUM_PORTS-1:0] linkUpPin,
  input  wire logic [tasf_pkg::NUM_PORTS-1:0] adminEnable,
  input  wire logic [tasf_pkg::NUM_PORTS-1:0] stpForward,
  output logic      [tasf_pkg::NUM_PORTS-1:0] portForwarding,
  // trunk configuration
  input  wire logic                      trunkCfgValid,
  input  wire tasf_pkg::tasf_trunk_op_t  trunkCfgOp,
  input  wire logic [tasf_pkg::GROUP_W-1:0] trunkCfgGroup,
  output logic                           trunkCfgAck,
  output logic                           trunkCfgReject,
  output logic      [tasf_pkg::NUM_GROUPS-1:0] trunkActive,
  // static unicast table writes
  input  wire logic                      ucWrEn,
  input  wire logic                      ucWrAdd,
  input  wire logic [$clog2(tasf_pkg::UC_DEPTH)-1:0] ucWrIdx,
  input  wire logic [tasf_pkg::MAC_W-1:0] ucWrMac,
  input  wire logic [tasf_pkg::PORT_W-1:0] ucWrPort,
  // static multicast table writes
  input  wire logic                      mcWrEn,
  input  wire logic                      mcWrAdd,
  input  wire logic [$clog2(tasf_pkg::MC_DEPTH)-1:0] mcWrIdx,
  input  wire logic [tasf_pkg::MAC_W-1:0] mcWrMac,
  input  wire logic [tasf_pkg::VLAN_W-1:0] mcWrVlan,
  input  wire logic [tasf_pkg::NUM_PORTS-1:0] mcWrMask,
  // forwarding request
  input  wire logic                      fwdValid,
  input  wire logic [tasf_pkg::PORT_W-1:0] fwdSrcPort,
  input  wire logic [tasf_pkg::MAC_W-1:0] fwdSrcMac,
  input  wire logic [tasf_pkg::MAC_W-1:0] fwdDstMac,
  input  wire logic [tasf_pkg::VLAN_W-1:0] fwdVlan,
  input  wire logic [tasf_pkg::HASH_W-1:0] fwdHash,
  input  wire logic [tasf_pkg::NUM_PORTS-1:0] fwdPortMask,
  // forwarding decision
  output logic                           outValid,
  output logic                           outDrop,
  output logic                           outLearnEn,
  output logic      [tasf_pkg::NUM_PORTS-1:0] outPortMask
);
  import tasf_pkg::*;

  function automatic logic [NUM_PORTS-1:0] groupMask(input int g);
    logic [NUM_PORTS-1:0] m;
    int                   base;
    int                   width;
    m = '0;
    base = 0;
    width = 0;
    if (g < QUAD_BASE) begin
      base = g;
      width = 1;
    end else if (g < OCT_BASE) begin
      base = 2 * (g - QUAD_BASE);
      width = 2;
    end else if (g < NUM_GROUPS) begin
      base = 4 * (g - OCT_BASE);
      width = 4;
    end
    for (int i = 0; i < width; i++) begin
      m[base + i] = 1'b1;
      m[base + i + PAIR_OFFSET] = 1'b1;
    end
    return m;
  endfunction

  // pick the n-th active member, n = hash mod active count
  function automatic logic [NUM_PORTS-1:0] pickMember(input logic [NUM_PORTS-1:0] mem,
                                                      input logic [HASH_W-1:0] h);
    logic [NUM_PORTS-1:0] r;
    int                   cnt;
    int                   n;
    int                   seen;
    r = '0;
    cnt = $countones(mem);
    seen = 0;
    n = (cnt == 0) ? 0 : int'(h) % cnt;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (mem[i]) begin
        if (seen == n) r[i] = 1'b1;
        seen++;
      end
    end
    return r;
  endfunction

  // link pins are asynchronous to the core clock
  logic [NUM_PORTS-1:0]  linkMeta;
  logic [NUM_PORTS-1:0]  linkUp;
  logic [NUM_PORTS-1:0]  usedMask;
  logic [NUM_PORTS-1:0]  memberUp;
  logic [NUM_GROUPS-1:0] next_trunkActive;
  logic                  next_trunkCfgAck;
  logic                  next_trunkCfgReject;
  logic [NUM_PORTS-1:0]  next_portForwarding;
  logic                  cfgBad;
  logic [NUM_PORTS-1:0]  stpGroupMask;
  logic                  ucHit;
  logic [PORT_W-1:0]     ucPort;
  logic                  mcHit;
  logic [NUM_PORTS-1:0]  mcMask;
  logic                  p1Valid;
  logic [PORT_W-1:0]     p1Src;
  logic [HASH_W-1:0]     p1Hash;
  logic [NUM_PORTS-1:0]  p1Mask;
  logic                  next_outValid;
  logic                  next_outDrop;
  logic                  next_outLearnEn;
  logic [NUM_PORTS-1:0]  next_outPortMask;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      linkMeta <= '0;
      linkUp   <= '0;
    end else begin
      linkMeta <= linkUpPin;
      linkUp   <= linkMeta;
    end
  end

  // a member carries traffic only when linked and enabled
  assign memberUp = linkUp & adminEnable;

  // trunk membership
  always_comb begin
    stpGroupMask = '0;
    usedMask = '0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (trunkActive[g]) usedMask = usedMask | groupMask(g);
    end
    next_trunkActive = trunkActive;
    cfgBad = 1'b0;
    if (trunkCfgValid) begin
      if (32'(trunkCfgGroup) >= NUM_GROUPS) begin
        cfgBad = 1'b1;
      end else if (trunkCfgOp == TASF_OP_ADD) begin
        cfgBad = (groupMask(int'(trunkCfgGroup)) & usedMask) != '0;
      end else begin
        cfgBad = !trunkActive[trunkCfgGroup];
      end
      if (!cfgBad) next_trunkActive[trunkCfgGroup] = (trunkCfgOp == TASF_OP_ADD);
    end
    next_trunkCfgAck    = trunkCfgValid && !cfgBad;
    next_trunkCfgReject = trunkCfgValid && cfgBad;
    // members follow the state of the trunk's lowest port
    next_portForwarding = stpForward;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (trunkActive[g]) begin
        stpGroupMask = groupMask(g);
        for (int i = 0; i < NUM_PORTS; i++) begin
          if (stpGroupMask[i]) next_portForwarding[i] = stpForward[lowestOf(g)];
        end
      end
    end
  end

  function automatic int lowestOf(input int g);
    logic [NUM_PORTS-1:0] m;
    int                   r;
    m = groupMask(g);
    r = 0;
    for (int i = NUM_PORTS - 1; i >= 0; i--) begin
      if (m[i]) r = i;
    end
    return r;
  endfunction

  always_ff @(posedge core_clk) begin
    if (reset) begin
      trunkActive    <= '0;
      trunkCfgAck    <= 1'b0;
      trunkCfgReject <= 1'b0;
      portForwarding <= '0;
    end else begin
      trunkActive    <= next_trunkActive;
      trunkCfgAck    <= next_trunkCfgAck;
      trunkCfgReject <= next_trunkCfgReject;
      portForwarding <= next_portForwarding;
    end
  end

  tasf_static_table #(.KEY_W(MAC_W), .DATA_W(PORT_W), .DEPTH(UC_DEPTH)) ucTable (
    .core_clk (core_clk),
    .reset    (reset),
    .wrEn     (ucWrEn),
    .wrAdd    (ucWrAdd),
    .wrIdx    (ucWrIdx),
    .wrKey    (ucWrMac),
    .wrData   (ucWrPort),
    .lkKey    (fwdSrcMac),
    .lkHit    (ucHit),
    .lkData   (ucPort)
  );

  tasf_static_table #(.KEY_W(MAC_W + VLAN_W), .DATA_W(NUM_PORTS), .DEPTH(MC_DEPTH)) mcTable (
    .core_clk (core_clk),
    .reset    (reset),
    .wrEn     (mcWrEn),
    .wrAdd    (mcWrAdd),
    .wrIdx    (mcWrIdx),
    .wrKey    ({mcWrMac, mcWrVlan}),
    .wrData   (mcWrMask),
    .lkKey    ({fwdDstMac, fwdVlan}),
    .lkHit    (mcHit),
    .lkData   (mcMask)
  );

  // forwarding decision, two cycles after the request
  always_comb begin
    logic [NUM_PORTS-1:0] m;
    logic [NUM_PORTS-1:0] gm;
    m  = '0;
    gm = '0;
    next_outDrop    = p1Valid && ucHit && (ucPort != p1Src);
    next_outLearnEn = p1Valid && !ucHit;
    m = mcHit ? mcMask : p1Mask;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      gm = groupMask(g);
      if (trunkActive[g] && (m & gm) != '0) begin
        m = (m & ~gm) | pickMember(gm & memberUp, p1Hash);
      end
    end
    next_outValid    = p1Valid;
    next_outPortMask = (next_outDrop || !p1Valid) ? '0 : m;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      p1Valid     <= 1'b0;
      p1Src       <= '0;
      p1Hash      <= '0;
      p1Mask      <= '0;
      outValid    <= 1'b0;
      outDrop     <= 1'b0;
      outLearnEn  <= 1'b0;
      outPortMask <= '0;
    end else begin
      p1Valid     <= fwdValid;
      p1Src       <= fwdSrcPort;
      p1Hash      <= fwdHash;
      p1Mask      <= fwdPortMask;
      outValid    <= next_outValid;
      outDrop     <= next_outDrop;
      outLearnEn  <= next_outLearnEn;
      outPortMask <= next_outPortMask;
    end
  end

  // checking helpers
  logic stpSplit;
  logic multiMember;
  always_comb begin
    stpSplit = 1'b0;
    multiMember = 1'b0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (trunkActive[g]) begin
        if ((next_portForwarding & groupMask(g)) != '0 && (next_portForwarding & groupMask(g)) != groupMask(g))
          stpSplit = 1'b1;
        if ($countones(next_outPortMask & groupMask(g)) > 1) multiMember = 1'b1;
      end
    end
  end

  a_reject_overlap: assert property (@(posedge core_clk) disable iff (reset)
    trunkCfgValid && trunkCfgOp == TASF_OP_ADD && 32'(trunkCfgGroup) < NUM_GROUPS &&
    (groupMask(int'(trunkCfgGroup)) & usedMask) != '0 |=> trunkCfgReject && $stable(trunkActive))
    else $error("overlapping trunk add was not rejected");
  a_reject_group: assert property (@(posedge core_clk) disable iff (reset)
    trunkCfgValid && 32'(trunkCfgGroup) >= NUM_GROUPS |=> trunkCfgReject && !trunkCfgAck)
    else $error("invalid trunk group accepted");
  a_pair_shape: assert property (@(posedge core_clk) disable iff (reset)
    trunkCfgValid && trunkCfgOp == TASF_OP_ADD && trunkCfgGroup == 5'h00 && usedMask[0] == 1'b0 &&
    usedMask[12] == 1'b0 |=> trunkActive[0] && usedMask[0] && usedMask[12] && $countones(usedMask) ==
    $countones($past(usedMask)) + 2)
    else $error("pair trunk did not join port n with n+12");
  a_stp_shared: assert property (@(posedge core_clk) disable iff (reset) !stpSplit)
    else $error("trunk members differ in forwarding state");
  a_one_member: assert property (@(posedge core_clk) disable iff (reset) !multiMember)
    else $error("frame sent to more than one member of a trunk");
  a_uc_drop: assert property (@(posedge core_clk) disable iff (reset)
    p1Valid && ucHit && ucPort != p1Src |=> outValid && outDrop && outPortMask == '0)
    else $error("static source on wrong port not dropped");
  a_learn_block: assert property (@(posedge core_clk) disable iff (reset)
    fwdValid ##1 ucHit |=> !outLearnEn)
    else $error("learning allowed for a static address");
  a_mc_restrict: assert property (@(posedge core_clk) disable iff (reset)
    p1Valid && mcHit && !next_outDrop |=> outValid && (outPortMask & ~$past(mcMask)) == '0)
    else $error("multicast forwarded outside member set");
  a_latency: assert property (@(posedge core_clk) disable iff (reset)
    fwdValid |-> ##2 outValid)
    else $error("decision not given two cycles after request");
  a_failover: assert property (@(posedge core_clk) disable iff (reset)
    p1Valid && !mcHit && (p1Mask & ~memberUp & usedMask) != '0 && !next_outDrop |=>
    (outPortMask & usedMask & ~$past(memberUp)) == '0)
    else $error("traffic sent to a down trunk member");

  c_uc_drop:    cover property (@(posedge core_clk) disable iff (reset) outValid && outDrop);
  c_mc_hit:     cover property (@(posedge core_clk) disable iff (reset) p1Valid && mcHit);
  c_trunk_add:  cover property (@(posedge core_clk) disable iff (reset) trunkCfgAck);
  c_oct_active: cover property (@(posedge core_clk) disable iff (reset) trunkActive[OCT_BASE]);
endmodule // tasf_forward

// ==== hw/tasf_pkg.sv ====
package tasf_pkg;
  localparam int NUM_PORTS   = 26;
  localparam int PORT_W      = 5;
  localparam int TRUNK_PORTS = 24;
  localparam int PAIR_OFFSET = 12;
  localparam int NUM_PAIRS   = 12;
  localparam int NUM_QUADS   = 6;
  localparam int NUM_OCTS    = 3;
  localparam int QUAD_BASE   = NUM_PAIRS;
  localparam int OCT_BASE    = NUM_PAIRS + NUM_QUADS;
  localparam int NUM_GROUPS  = NUM_PAIRS + NUM_QUADS + NUM_OCTS;
  localparam int GROUP_W     = 5;
  localparam int MAC_W       = 48;
  localparam int VLAN_W      = 12;
  localparam int HASH_W      = 8;
  localparam int UC_DEPTH    = 16;
  localparam int MC_DEPTH    = 16;
  localparam int LOOKUP_LAT  = 2;

  typedef enum logic {TASF_OP_ADD, TASF_OP_DEL} tasf_trunk_op_t;
endpackage

// ==== hw/tasf_static_table.sv ====
`timescale 1ns/1ps
// fully associative table; entries never age, only writes change them
module tasf_static_table #(
  parameter int KEY_W  = 48,
  parameter int DATA_W = 5,
  parameter int DEPTH  = 16,
  parameter int IDX_W  = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // software write: add/modify or delete one entry
  input  wire logic              wrEn,
  input  wire logic              wrAdd,
  input  wire logic [IDX_W-1:0]  wrIdx,
  input  wire logic [KEY_W-1:0]  wrKey,
  input  wire logic [DATA_W-1:0] wrData,
  // lookup, answer one cycle later
  input  wire logic [KEY_W-1:0]  lkKey,
  output logic                   lkHit,
  output logic      [DATA_W-1:0] lkData
);
  logic [DEPTH-1:0]              entryValid;
  logic [DEPTH-1:0]              next_entryValid;
  logic [KEY_W-1:0]              entryKey       [DEPTH];
  logic [KEY_W-1:0]              next_entryKey  [DEPTH];
  logic [DATA_W-1:0]             entryData      [DEPTH];
  logic [DATA_W-1:0]             next_entryData [DEPTH];
  logic                          next_lkHit;
  logic [DATA_W-1:0]             next_lkData;

  always_comb begin
    next_entryValid = entryValid;
    next_entryKey   = entryKey;
    next_entryData  = entryData;
    if (wrEn) begin
      next_entryValid[wrIdx] = wrAdd;
      next_entryKey[wrIdx]   = wrKey;
      next_entryData[wrIdx]  = wrData;
    end
    next_lkHit  = 1'b0;
    next_lkData = '0;
    // lowest index wins if software loaded one key twice
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (entryValid[i] && entryKey[i] == lkKey) begin
        next_lkHit  = 1'b1;
        next_lkData = entryData[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      entryValid <= '0;
      lkHit      <= 1'b0;
      lkData     <= '0;
    end else begin
      entryValid <= next_entryValid;
      lkHit      <= next_lkHit;
      lkData     <= next_lkData;
    end
    entryKey  <= next_entryKey;
    entryData <= next_entryData;
  end
endmodule // tasf_static_table

// ==== bench/tasf_peer_model.sv ====
`timescale 1ns/1ps
// far end of every port: the link stays up unless the bench pulls the cable
module tasf_peer_model
  import tasf_pkg::*;
(
  // cable control from the bench
  input  wire logic [NUM_PORTS-1:0] cutMask,
  // link status pins seen by the switch
  output wire logic [NUM_PORTS-1:0] linkUpPin
);
  // pins move off the core clock grid, so the switch must synchronise them
  // the bench pulls cables through cutMask; the peer only follows them
  assign #3 linkUpPin = ~cutMask;
endmodule // tasf_peer_model

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import tasf_pkg::*;
  localparam int MAX_CYC = 3000;
  logic                   core_clk, reset, trunkCfgValid, trunkCfgAck, trunkCfgReject;
  logic [NUM_PORTS-1:0]   linkUpPin, adminEnable, stpForward, cutMask, portForwarding;
  tasf_trunk_op_t         trunkCfgOp;
  logic [GROUP_W-1:0]     trunkCfgGroup;
  logic [NUM_GROUPS-1:0]  trunkActive, expActive;
  logic                   ucWrEn, ucWrAdd, mcWrEn, mcWrAdd, fwdValid, outValid, outDrop, outLearnEn;
  logic [3:0]             ucWrIdx, mcWrIdx;
  logic [MAC_W-1:0]       ucWrMac, mcWrMac, fwdSrcMac, fwdDstMac;
  logic [PORT_W-1:0]      ucWrPort, fwdSrcPort;
  logic [VLAN_W-1:0]      mcWrVlan, fwdVlan;
  logic [NUM_PORTS-1:0]   mcWrMask, fwdPortMask, outPortMask;
  logic [HASH_W-1:0]      fwdHash;
  int                     failCount, nChecks, cyc;

  tasf_forward u_dut (
    .core_clk, .reset, .linkUpPin, .adminEnable, .stpForward, .portForwarding,
    .trunkCfgValid, .trunkCfgOp, .trunkCfgGroup, .trunkCfgAck, .trunkCfgReject, .trunkActive,
    .ucWrEn, .ucWrAdd, .ucWrIdx, .ucWrMac, .ucWrPort,
    .mcWrEn, .mcWrAdd, .mcWrIdx, .mcWrMac, .mcWrVlan, .mcWrMask,
    .fwdValid, .fwdSrcPort, .fwdSrcMac, .fwdDstMac, .fwdVlan, .fwdHash, .fwdPortMask,
    .outValid, .outDrop, .outLearnEn, .outPortMask
  );
  tasf_peer_model u_peer (.cutMask, .linkUpPin);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic testDone();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == MAX_CYC) begin
      failCount++;
      $display("unexpected at %0t: run did not finish", $time);
      testDone();
    end
  end

  task automatic chk(input bit ok, input string msg);
    nChecks++;
    if (!ok) begin
      failCount++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // every task starts and ends 1 ns after a rising edge
  task automatic step(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // software only ever adds or removes a whole group at once
  task automatic cfg(input tasf_trunk_op_t op, input logic [GROUP_W-1:0] g, input bit ok);
    trunkCfgValid = 1'b1;
    trunkCfgOp = op;
    trunkCfgGroup = g;
    step();
    chk(trunkCfgAck === ok && trunkCfgReject === !ok, "trunk answer");
    if (ok) expActive[g] = (op == TASF_OP_ADD);
    chk(trunkActive === expActive, "trunk state");
    trunkCfgValid = 1'b0;
    step();
  endtask

  task automatic ucWr(input logic add, input logic [MAC_W-1:0] mac, input logic [PORT_W-1:0] p);
    ucWrEn = 1'b1;
    ucWrAdd = add;
    ucWrIdx = 4'h2;
    ucWrMac = mac;
    ucWrPort = p;
    step();
    ucWrEn = 1'b0;
  endtask

  task automatic mcWr(input logic add, input logic [NUM_PORTS-1:0] m);
    mcWrEn = 1'b1;
    mcWrAdd = add;
    mcWrIdx = 4'h5;
    mcWrMac = 48'h01005e000001;
    mcWrVlan = 12'h005;
    mcWrMask = m;
    step();
    mcWrEn = 1'b0;
  endtask

  task automatic fwd(input logic [PORT_W-1:0] sp, input logic [MAC_W-1:0] sm, dm,
                     input logic [VLAN_W-1:0] vl, input logic [HASH_W-1:0] h,
                     input logic [NUM_PORTS-1:0] m, input bit eDrop, eLearn,
                     input logic [NUM_PORTS-1:0] eMask);
    fwdValid = 1'b1;
    fwdSrcPort = sp;
    fwdSrcMac = sm;
    fwdDstMac = dm;
    fwdVlan = vl;
    fwdHash = h;
    fwdPortMask = m;
    step();
    fwdValid = 1'b0;
    chk(outValid === 1'b0, "decision too early");
    step();
    chk(outValid === 1'b1 && outDrop === eDrop && outLearnEn === eLearn && outPortMask === eMask, "decision");
  endtask

  task automatic testTrunkCfg();
    cfg(TASF_OP_ADD, 5'd21, 0);
    cfg(TASF_OP_ADD, 5'd31, 0);
    cfg(TASF_OP_DEL, 5'd0, 0);
    cfg(TASF_OP_ADD, 5'd0, 1);
    cfg(TASF_OP_ADD, 5'd12, 0);
    cfg(TASF_OP_ADD, 5'd18, 0);
    cfg(TASF_OP_ADD, 5'd19, 1);
    cfg(TASF_OP_ADD, 5'd14, 0);
    cfg(TASF_OP_ADD, 5'd13, 1);
    cfg(TASF_OP_DEL, 5'd13, 1);
    cfg(TASF_OP_DEL, 5'd19, 1);
    $display("trunk config test done");
  endtask

  // pair 0 joins port indices 0 and 12; index 25 never trunks
  task automatic testBalance();
    fwd(5'd20, 48'h020000000b01, 48'h020000000b02, 12'h001, 8'h00, 26'h2001001, 0, 1, 26'h2000001);
    fwd(5'd20, 48'h020000000b01, 48'h020000000b02, 12'h001, 8'hff, 26'h2001001, 0, 1, 26'h2001000);
    cutMask[0] = 1'b1;
    adminEnable[0] = 1'b0;
    step(4);
    fwd(5'd20, 48'h020000000b01, 48'h020000000b02, 12'h001, 8'h00, 26'h2001001, 0, 1, 26'h2001000);
    cutMask[12] = 1'b1;
    step(4);
    fwd(5'd20, 48'h020000000b01, 48'h020000000b02, 12'h001, 8'h00, 26'h2001001, 0, 1, 26'h2000000);
    cutMask = '0;
    adminEnable = '1;
    step(4);
    $display("trunk balance test done");
  endtask

  task automatic testStp();
    stpForward[12] = 1'b0;
    step(3);
    chk(portForwarding[12] === 1'b1 && portForwarding[0] === 1'b1, "member state");
    stpForward[0] = 1'b0;
    stpForward[12] = 1'b1;
    step(3);
    chk(portForwarding[12] === 1'b0 && portForwarding[0] === 1'b0, "member state");
    stpForward = '1;
    step(3);
    $display("spanning tree test done");
  endtask

  task automatic testUnicast();
    ucWr(1'b1, 48'h020000000a01, 5'd3);
    fwd(5'd3, 48'h020000000a01, 48'h020000000c01, 12'h001, 8'h00, 26'h0000100, 0, 0, 26'h0000100);
    fwd(5'd7, 48'h020000000a01, 48'h020000000c01, 12'h001, 8'h00, 26'h0000100, 1, 0, 26'h0000000);
    ucWr(1'b1, 48'h020000000a01, 5'd7);
    fwd(5'd7, 48'h020000000a01, 48'h020000000c01, 12'h001, 8'h00, 26'h0000100, 0, 0, 26'h0000100);
    fwd(5'd3, 48'h020000000a01, 48'h020000000c01, 12'h001, 8'h00, 26'h0000100, 1, 0, 26'h0000000);
    ucWr(1'b0, 48'h020000000a01, 5'd7);
    fwd(5'd3, 48'h020000000a01, 48'h020000000c01, 12'h001, 8'h00, 26'h0000100, 0, 1, 26'h0000100);
    $display("static unicast test done");
  endtask

  task automatic testMulticast();
    mcWr(1'b1, 26'h2000022);
    fwd(5'd9, 48'h020000000d01, 48'h01005e000001, 12'h005, 8'h00, 26'h0000400, 0, 1, 26'h2000022);
    fwd(5'd9, 48'h020000000d01, 48'h01005e000001, 12'h006, 8'h00, 26'h0000400, 0, 1, 26'h0000400);
    mcWr(1'b1, 26'h0000088);
    fwd(5'd9, 48'h020000000d01, 48'h01005e000001, 12'h005, 8'h00, 26'h0000400, 0, 1, 26'h0000088);
    mcWr(1'b0, 26'h0000000);
    fwd(5'd9, 48'h020000000d01, 48'h01005e000001, 12'h005, 8'h00, 26'h0000400, 0, 1, 26'h0000400);
    $display("static multicast test done");
  endtask

  initial begin
    reset = 1'b1;
    {trunkCfgValid, ucWrEn, ucWrAdd, mcWrEn, mcWrAdd, fwdValid} = '0;
    trunkCfgOp = TASF_OP_ADD;
    {trunkCfgGroup, ucWrIdx, mcWrIdx, ucWrPort, fwdSrcPort, fwdHash} = '0;
    {ucWrMac, mcWrMac, fwdSrcMac, fwdDstMac, mcWrVlan, fwdVlan} = '0;
    {mcWrMask, fwdPortMask, cutMask, expActive} = '0;
    adminEnable = '1;
    stpForward = '1;
    step(8);
    reset = 1'b0;
    step(3);
    testTrunkCfg();
    testBalance();
    testStp();
    testUnicast();
    testMulticast();
    testDone();
  end
endmodule // testbench
